/* rtl/ffc_core.sv */
// per-pixel black-level and shading correction with reference storage
// Notes on behaviour
// RULE_01 - Both corrections act on each pixel position with that pixel's own references.
// RULE_02 - Red, green and blue keep their own references and are corrected independently.
// RULE_03 - Four black sets and four shading sets are stored and picked by a select input.
// RULE_04 - Black recording stores each raw pixel value as that pixel's black reference.
// RULE_05 - White recording stores raw minus the pixel's black reference as its white reference.
// RULE_06 - Full correction outputs (raw - black) times max brightness divided by white reference.
// RULE_07 - Reference sets can be generated inside the block from captured lines.
// RULE_08 - Sets downloaded by the host land in the same storage and are used the same way.
// RULE_09 - The front end delivers raw samples as 14-bit unsigned values.
// RULE_10 - Black-level correction comes first and shading correction second.
// RULE_11 - Negative differences clamp to zero, results saturate, a zero white ref gives max.
`default_nettype none
`include "ffc_defines.svh"
module ffc_core
    import ffc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire ffc_mode_e mode,
    input wire logic black_corr_en,
    input wire logic shading_corr_en,
    input wire logic [`FFC_SET_W-1:0] black_set_sel,
    input wire logic [`FFC_SET_W-1:0] white_set_sel,
    input wire logic in_valid,
    output logic in_ready,
    input wire ffc_rgb_s raw_pixel_value,
    input wire logic dl_valid,
    input wire ffc_dl_s dl_word,
    output logic out_valid,
    input wire logic out_ready,
    output ffc_rgb_s corrected_pixel,
    output logic [`FFC_IDX_W-1:0] pixel_index
);
    localparam int ADDR_W = `FFC_SET_W + `FFC_IDX_W;
    localparam int ENTRIES = `FFC_SETS * `FFC_LINE_LEN;
    localparam int RGB_W = $bits(ffc_rgb_s);

    logic in_ready_reg;
    logic in_fire;
    logic [`FFC_IDX_W-1:0] idx_reg;
    logic [`FFC_IDX_W-1:0] cur_idx;
    // stage a: raw pixel with its references read
    logic valid_a_reg;
    ffc_rgb_s pix_a_reg;
    ffc_mode_e mode_a_reg;
    logic black_en_a_reg;
    logic white_en_a_reg;
    logic [`FFC_SET_W-1:0] wsel_a_reg;
    logic [`FFC_IDX_W-1:0] idx_a_reg;
    // unpacked so each colour lane has a driver of its own
    ffc_pix_t black_a_reg [`FFC_COLOURS];
    ffc_pix_t white_a_reg [`FFC_COLOURS];
    // stage b: result on its way into the fifo
    logic valid_b_reg;
    ffc_rgb_s res_b_reg;
    ffc_rgb_s res_next;
    ffc_pix_t res_ch [`FFC_COLOURS];
    ffc_pix_t diff_a [`FFC_COLOURS];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [RGB_W-1:0] fifo_out_data;
    logic [`FFC_FIFO_LVL_W-1:0] fifo_level;
    logic [`FFC_FIFO_LVL_W-1:0] in_flight;
    logic out_valid_reg;
    ffc_rgb_s out_pix_reg;
    logic [`FFC_IDX_W-1:0] pixel_index_reg;

    assign in_fire = in_valid && in_ready_reg;
    // line_start forces the position counter back to the first pixel
    assign cur_idx = raw_pixel_value.line_start ? '0 : idx_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idx_reg <= '0;
            pixel_index_reg <= '0;
        end else if (in_fire) begin
            idx_reg <= (cur_idx == `FFC_IDX_W'(`FFC_LINE_LEN - 1)) ? '0 : cur_idx + 1'b1;
            pixel_index_reg <= cur_idx;
        end
    end

    genvar c;
    generate
        for (c = 0; c < `FFC_COLOURS; c++) begin : g_colour
            // one black and one white store per colour, each holding all four sets
            ffc_pix_t black_mem [ENTRIES]; // RULE_02
            ffc_pix_t white_mem [ENTRIES]; // RULE_02
            logic dl_hit;
            ffc_pix_t prod_div_raw;
            logic [`FFC_PROD_W-1:0] product;
            logic [`FFC_PROD_W-1:0] quotient;
            ffc_pix_t stage_one;

            assign dl_hit = dl_valid && (dl_word.colour == 2'(c));

            // download wins the write port; a recorded pixel colliding with it is dropped
            always_ff @(posedge ref_clk) begin
                if (dl_hit && !dl_word.is_white) begin
                    black_mem[{dl_word.set, dl_word.index}] <= dl_word.value; // RULE_08
                end else if (in_fire && mode == FFC_MODE_REC_BLACK) begin
                    black_mem[{black_set_sel, cur_idx}] <= raw_pixel_value.ch[c]; // RULE_04
                end
            end

            always_ff @(posedge ref_clk) begin
                if (dl_hit && dl_word.is_white) begin
                    white_mem[{dl_word.set, dl_word.index}] <= dl_word.value; // RULE_08
                end else if (valid_a_reg && mode_a_reg == FFC_MODE_REC_WHITE) begin
                    white_mem[{wsel_a_reg, idx_a_reg}] <= diff_a[c]; // RULE_05 RULE_07
                end
            end

            always_ff @(posedge ref_clk) begin
                if (in_fire) begin
                    black_a_reg[c] <= black_mem[{black_set_sel, cur_idx}]; // RULE_01 RULE_03
                    white_a_reg[c] <= white_mem[{white_set_sel, cur_idx}]; // RULE_01 RULE_03
                end
            end

            // black subtraction, clamped at zero
            assign diff_a[c] = (pix_a_reg.ch[c] > black_a_reg[c])
                ? pix_a_reg.ch[c] - black_a_reg[c] : '0; // RULE_11
            assign stage_one = black_en_a_reg ? diff_a[c] : pix_a_reg.ch[c]; // RULE_10
            assign product = `FFC_PROD_W'(stage_one) * `FFC_PROD_W'(`FFC_MAX_BRIGHT); // RULE_06
            // a single-cycle divider trades timing margin for pipeline depth
            assign quotient = (white_a_reg[c] == '0) ? `FFC_PROD_W'(`FFC_MAX_BRIGHT)
                : product / `FFC_PROD_W'(white_a_reg[c]); // RULE_11
            assign prod_div_raw = (quotient > `FFC_PROD_W'(`FFC_MAX_BRIGHT))
                ? `FFC_MAX_BRIGHT : quotient[`FFC_PIX_W-1:0]; // RULE_11

            always_comb begin
                if (mode_a_reg == FFC_MODE_CORRECT && white_en_a_reg) begin
                    res_ch[c] = prod_div_raw; // RULE_06 RULE_10
                end else if (mode_a_reg == FFC_MODE_CORRECT) begin
                    res_ch[c] = stage_one;
                end else begin
                    res_ch[c] = pix_a_reg.ch[c];
                end
            end
        end
    endgenerate

    // one process packs the lanes, so the result word has a single driver
    always_comb begin
        res_next.line_start = pix_a_reg.line_start;
        for (int k = 0; k < `FFC_COLOURS; k++) begin
            res_next.ch[k] = res_ch[k];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            valid_a_reg <= 1'b0;
            pix_a_reg <= '0;
            mode_a_reg <= FFC_MODE_PASS;
            black_en_a_reg <= 1'b0;
            white_en_a_reg <= 1'b0;
            wsel_a_reg <= '0;
            idx_a_reg <= '0;
        end else begin
            valid_a_reg <= in_fire;
            if (in_fire) begin
                pix_a_reg <= raw_pixel_value; // RULE_09
                mode_a_reg <= mode;
                black_en_a_reg <= black_corr_en;
                white_en_a_reg <= shading_corr_en;
                wsel_a_reg <= white_set_sel;
                idx_a_reg <= cur_idx;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            valid_b_reg <= 1'b0;
            res_b_reg <= '0;
        end else begin
            valid_b_reg <= valid_a_reg;
            if (valid_a_reg) begin
                res_b_reg <= res_next;
            end
        end
    end

    // credit: pixels in flight must always find room in the fifo
    assign in_flight = `FFC_FIFO_LVL_W'(valid_a_reg) + `FFC_FIFO_LVL_W'(valid_b_reg)
        + `FFC_FIFO_LVL_W'(in_fire);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            in_ready_reg <= 1'b0;
        end else begin
            in_ready_reg <= fifo_in_ready && (fifo_level + in_flight <= `FFC_CREDIT_MAX);
        end
    end

    ffc_fifo #(
        .WIDTH(RGB_W),
        .DEPTH(`FFC_FIFO_DEPTH),
        .LVL_W(`FFC_FIFO_LVL_W)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(valid_b_reg),
        .in_ready(fifo_in_ready),
        .in_data(res_b_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // output register keeps the ports straight off flip-flops
    assign fifo_pop = fifo_out_valid && (!out_valid_reg || out_ready);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_valid_reg <= 1'b0;
            out_pix_reg <= '0;
        end else if (!out_valid_reg || out_ready) begin
            out_valid_reg <= fifo_out_valid;
            if (fifo_out_valid) begin
                out_pix_reg <= ffc_rgb_s'(fifo_out_data);
            end
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign corrected_pixel = out_pix_reg;
    assign pixel_index = pixel_index_reg;
endmodule
`default_nettype wire

/* rtl/ffc_defines.svh */
// constants for the flat-field pixel correction block
`ifndef FFC_DEFINES_SVH
`define FFC_DEFINES_SVH
`define FFC_PIX_W 14
`define FFC_MAX_BRIGHT 14'h3FFF
`define FFC_COLOURS 3
`define FFC_SETS 4
`define FFC_SET_W 2
`define FFC_LINE_LEN 1024
`define FFC_IDX_W 10
`define FFC_FIFO_DEPTH 8
`define FFC_FIFO_LVL_W 4
`define FFC_CREDIT_MAX 4'h5
`define FFC_PROD_W 28
`endif

/* rtl/ffc_pkg.sv */
// types shared by the flat-field pixel correction block
`default_nettype none
`include "ffc_defines.svh"
package ffc_pkg;
    typedef logic [`FFC_PIX_W-1:0] ffc_pix_t;
    typedef enum logic [3:0] {
        FFC_MODE_PASS = 4'h1,
        FFC_MODE_REC_BLACK = 4'h2,
        FFC_MODE_REC_WHITE = 4'h4,
        FFC_MODE_CORRECT = 4'h8
    } ffc_mode_e;
    typedef struct packed {
        logic line_start;
        ffc_pix_t [`FFC_COLOURS-1:0] ch;
    } ffc_rgb_s;
    typedef struct packed {
        logic is_white;
        logic [`FFC_SET_W-1:0] set;
        logic [1:0] colour;
        logic [`FFC_IDX_W-1:0] index;
        ffc_pix_t value;
    } ffc_dl_s;
endpackage
`default_nettype wire

/* rtl/ffc_fifo.sv */
// parameterised valid/ready fifo for the corrected pixel stream
`default_nettype none
module ffc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LVL_W-1:0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [LVL_W-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != LVL_W'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign level = count_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + LVL_W'(push) - LVL_W'(pop);
        end
    end
endmodule
`default_nettype wire

/* testbench/ffc_chk.sv */
// port checks on the correction core
`default_nettype none
`include "ffc_defines.svh"
module ffc_chk
    import ffc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire ffc_rgb_s raw_pixel_value,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire ffc_rgb_s corrected_pixel,
    input wire logic [`FFC_IDX_W-1:0] pixel_index
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic acc = in_valid && in_ready;
    logic [4:0] inflight;
    logic seen_pixel;
    // the first pixel after reset has no predecessor to step from
    always_ff @(posedge ref_clk) begin
        if (reset) seen_pixel <= 1'b0;
        else if (acc) seen_pixel <= 1'b1;
    end
    // pixels taken but not yet handed on; zero means the path is empty
    always_ff @(posedge ref_clk) begin
        if (reset) inflight <= 5'h0;
        else inflight <= inflight + 5'(acc) - 5'(out_valid && out_ready);
    end
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !in_ready && !out_valid
        && corrected_pixel == '0 && pixel_index == 10'h0) else $error("not idle in reset");
    a_ready_release: assert property ($fell(reset) |=> in_ready)
        else $error("no ready after reset");
    a_out_stands: assert property (out_valid && !out_ready |=> out_valid &&
        $stable(corrected_pixel)) else $error("output moved while stalled");
    a_index_restart: assert property (acc && raw_pixel_value.line_start |=>
        pixel_index == 10'h0) else $error("line start not at position zero");
    a_index_step: assert property (acc && seen_pixel && !raw_pixel_value.line_start |=>
        pixel_index == $past(pixel_index) + 10'h1) else $error("position not stepped");
    a_index_hold: assert property (!acc |=> $stable(pixel_index))
        else $error("position moved without a pixel");
    a_first_latency: assert property (acc && inflight == 5'h0 |->
        !out_valid [*2] ##[1:3] out_valid) else $error("latency off on empty path");
    a_answer_bound: assert property (acc |-> ##[1:300] out_valid)
        else $error("taken pixel never answered");
    cover property (acc && raw_pixel_value.line_start);
    cover property (out_valid && !out_ready);
    cover property (acc && !in_ready ##1 !in_ready);
endmodule
`default_nettype wire

/* testbench/ffc_sink.sv */
// downstream stage model that stalls on request and logs pixels
`default_nettype none
module ffc_sink
    import ffc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire ffc_rgb_s corrected_pixel
);
    timeunit 1ns;
    timeprecision 100ps;
    ffc_rgb_s got[$];
    logic [1:0] tick = 2'h0;
    initial out_ready = 1'b0;
    // when stalling, ready only one cycle in four so the fifo backs up until the credit limit refuses input
    always @(negedge ref_clk) begin
        tick <= tick + 2'h1;
        out_ready <= !reset && !(stall && tick != 2'h3);
    end
    always @(posedge ref_clk) begin
        if (!reset && out_valid && out_ready) got.push_back(corrected_pixel);
    end
endmodule
`default_nettype wire

/* testbench/flat_field_pixel_correction_tb.sv */
// self-checking bench for the correction core
`default_nettype none
`include "ffc_defines.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module flat_field_pixel_correction_tb import ffc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, reset = 1'b1, in_valid = 1'b0, dl_valid = 1'b0, stall = 1'b0;
    logic be = 1'b0, se = 1'b0, in_ready, out_valid, out_ready;
    logic [1:0] bs = 2'h0, ws = 2'h0;
    ffc_mode_e mode = FFC_MODE_PASS;
    ffc_rgb_s raw = '0, corrected_pixel;
    ffc_dl_s dl_word = '0;
    logic [`FFC_IDX_W-1:0] pixel_index;
    ffc_rgb_s exp_q[$];
    int mismatches = 0, checks_done = 0;
    int refused = 0;
    int z[3] = '{0, 0, 0};
    always #2.5 ref_clk = ~ref_clk;
    ffc_core i_ffc_core(.ref_clk, .reset, .mode, .black_corr_en(be), .shading_corr_en(se),
        .black_set_sel(bs), .white_set_sel(ws), .in_valid, .in_ready, .raw_pixel_value(raw),
        .dl_valid, .dl_word, .out_valid, .out_ready, .corrected_pixel, .pixel_index);
    ffc_sink i_ffc_sink(.ref_clk, .reset, .stall, .out_valid, .out_ready, .corrected_pixel);
    function automatic logic [13:0] model(int r, int b, int w, bit b_en, bit s_en);
        int d = b_en ? (r > b ? r - b : 0) : r;
        if (s_en) d = (w == 0 || d * 16383 / w > 16383) ? 16383 : d * 16383 / w;
        return d[13:0];
    endfunction
    task automatic send(ffc_mode_e m, bit ls, bit b_en, bit s_en, int bsel, int wsel,
        int p[3], int b[3], int w[3]);
        ffc_rgb_s e;
        int n = 0;
        @(negedge ref_clk);
        mode = m;
        in_valid = 1'b1;
        be = b_en;
        se = s_en;
        bs = bsel[1:0];
        ws = wsel[1:0];
        raw.line_start = ls;
        e.line_start = ls;
        for (int c = 0; c < 3; c++) begin
            raw.ch[c] = p[c][13:0];
            e.ch[c] = m == FFC_MODE_CORRECT ? model(p[c], b[c], w[c], b_en, s_en) : p[c][13:0];
        end
        exp_q.push_back(e);
        while (in_ready !== 1'b1 && n++ < 99) begin
            refused++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
    task automatic drain(string nm);
        ffc_rgb_s a, g;
        int n = 0;
        @(negedge ref_clk);
        in_valid = 1'b0;
        while (i_ffc_sink.got.size() < exp_q.size() && n++ < 500) @(negedge ref_clk);
        `CHK(nm, exp_q.size(), i_ffc_sink.got.size())
        while (exp_q.size() > 0 && i_ffc_sink.got.size() > 0) begin
            a = exp_q.pop_front();
            g = i_ffc_sink.got.pop_front();
            `CHK(nm, a, g)
        end
        exp_q.delete();
        i_ffc_sink.got.delete();
    endtask
    task automatic dl(bit wh, int c, int v);
        @(negedge ref_clk);
        dl_valid = 1'b1;
        dl_word = '{wh, 2'h3, c[1:0], 10'h0, v[13:0]};
    endtask
    task automatic t_pass();
        // long stalled burst, so the input side must refuse for a while
        stall = 1'b1;
        for (int i = 0; i < 14; i++) send(FFC_MODE_PASS, i == 0, 0, 0, 0, 0,
            '{i * 1170, 16383 - i, i}, z, z);
        drain("pass");
        `CHK("pass index", 10'h00D, pixel_index)
        `CHK("pass refused", 1'h1, refused > 0)
        stall = 1'b0;
    endtask
    task automatic t_record();
        int bb[3] = '{100, 110, 120};
        int ww[3] = '{8000, 9000, 0};
        send(FFC_MODE_REC_BLACK, 1, 0, 0, 1, 0, bb, z, z);
        drain("rec black");
        // colour 2 records below black, so its white ref clamps to zero
        send(FFC_MODE_REC_WHITE, 1, 0, 0, 1, 2, '{8100, 9110, 50}, z, z);
        drain("rec white");
        for (int k = 0; k < 4; k++) send(FFC_MODE_CORRECT, 1, k[0], k[1], 1, 2,
            '{4100, 110, 3000}, bb, ww);
        drain("correct");
    endtask
    task automatic t_download();
        int bb[3] = '{200, 0, 5000};
        int ww[3] = '{16383, 100, 1000};
        for (int c = 0; c < 3; c++) begin
            dl(0, c, bb[c]);
            dl(1, c, ww[c]);
        end
        @(negedge ref_clk);
        dl_valid = 1'b0;
        for (int k = 0; k < 4; k++) send(FFC_MODE_CORRECT, 1, k[0], k[1], 3, 3,
            '{1200, 50, 5100}, bb, ww);
        drain("download");
        send(FFC_MODE_CORRECT, 1, 1, 1, 1, 2, '{4100, 110, 3000}, '{100, 110, 120},
            '{8000, 9000, 0});
        drain("set kept");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        t_pass();
        t_record();
        t_download();
        give_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule
bind ffc_core ffc_chk i_ffc_chk(.ref_clk, .reset, .in_valid, .in_ready, .raw_pixel_value,
    .out_valid, .out_ready, .corrected_pixel, .pixel_index);
`default_nettype wire
